// ### fbs_pkg.sv
// Shared constants and types for the flow-through burst SRAM port.
// Assumes one clock domain; files that use these names refer to them as fbs_pkg::name.
`default_nettype none

package fbs_pkg;

  // Array organisation of the wide variant.
  localparam int ADDR_W = 18;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int BURST_W = 2;

  // Depth of the access log buffer.
  localparam int LOG_DEPTH = 4;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_LOG = 8'h08;

  // Control register fields and reset value.
  localparam int CTRL_WR_BLOCK = 0;
  localparam int CTRL_LOG_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status register fields, then the valid bit of the log register.
  localparam int ST_LOW_POWER = 0;
  localparam int ST_ACTIVE = 1;
  localparam int ST_LOW_BITS = 2;
  localparam int ST_LOG_OVF = 4;
  localparam int ST_LOG_AVAIL = 5;
  localparam int ST_MASK = 8;
  localparam int ST_CYCLE = 12;
  localparam int LOG_VALID_BIT = 31;

  // Kind of memory cycle currently in progress.
  typedef enum logic [1:0] {
    CYC_DESEL,
    CYC_READ,
    CYC_WRITE
  } fbs_cyc_e;

  // Synchronous control pins, as they travel together into the decoder.
  typedef struct packed {
    logic proc_n;
    logic ctrl_n;
    logic step_n;
    logic se1_n;
    logic se2;
    logic se3_n;
    logic all_n;
    logic qual_n;
  } fbs_ctl_s;

endpackage

`default_nettype wire

// ### fbs_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
// Assumes DEPTH is a power of two so the pointers wrap by themselves.
`default_nettype none

module fbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (count_reg != FULL_COUNT);
  assign out_valid = (count_reg != '0);
  assign out_data = store_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Entries need no reset; only the pointers and count define validity.
  always_ff @(posedge clk) begin
    if (push) begin
      store_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and occupancy move together so they never disagree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ### fbs_burst_ctr.sv
// Burst address counter that produces the two lowest address bits.
// Assumes the caller gates load and step with its own clock-stop condition.
`default_nettype none

module fbs_burst_ctr #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic step,
  input wire logic interleave,
  output logic [W-1:0] low_bits
);

  logic [W-1:0] base_reg;
  logic [W-1:0] count_reg;

  // The loaded start bits stay fixed for the whole burst.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_reg <= '0;
    end else if (load) begin
      base_reg <= load_val;
    end
  end

  // The step count wraps at four, so the burst stays inside its line.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (load) begin
      count_reg <= '0;
    end else if (step) begin
      count_reg <= count_reg + 1'b1; // R17
    end
  end

  // Order select is read live because it is a static strap.
  assign low_bits = interleave ? (base_reg ^ count_reg) : W'(base_reg + count_reg); // R17

endmodule

`default_nettype wire

// ### fbs_port.sv
// Flow-through burst SRAM port with its array, burst logic and a bus slave.
// Assumes the memory pins are synchronous to hclk and the bus is AHB-Lite.
//
// What this block does
// R1 - Address, data and controls are sampled at the clock; enable, order, sleep are live.
// R2 - A write starts on its own edge and is timed inside the block.
// R3 - With the qualifier asserted, only lanes whose lane write is asserted change.
// R4 - Global write, or all lanes plus qualifier, writes every lane.
// R5 - Array is 256K by 36 in four lanes, or 512K by 18 in two.
// R6 - Either address strobe starts a burst; later addresses come from the counter.
// R7 - Sampled burst advance steps the burst address once in the chosen order.
// R8 - Order select is a static strap: low linear, high interleaved.
// R9 - Controller strobe aborts a burst, loads an address, starts read, write or deselect.
// R10 - Processor strobe does the same, but is ignored while primary enable is high.
// R11 - Output enable drives the data lanes when low, releases them when high.
// R12 - Read data flows straight from the array with no output register.
// R13 - The far side wires its two lowest address bits to the burst bits.
// R14 - Primary enable is active low; negated it blocks processor strobe, deselects.
// R15 - The active-high depth enable must also be asserted to select.
// R16 - Sleep stops internal clocking; after release stays low power until an access.
// R17 - The counter touches only two bits and wraps within four locations.
// R18 - Qualifier with no lanes and no global write is a read.
`default_nettype none

module fbs_port #(
  parameter int ADDR_W = fbs_pkg::ADDR_W,
  parameter int LANES = fbs_pkg::LANES,
  parameter int LANE_W = fbs_pkg::LANE_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [ADDR_W-fbs_pkg::BURST_W-1:0] addr_in,
  input wire logic [fbs_pkg::BURST_W-1:0] burst_low_bits,
  input wire logic [LANES*LANE_W-1:0] data_io_lane_i,
  output logic [LANES*LANE_W-1:0] data_io_lane_o,
  output logic data_io_lane_oe,
  input wire logic out_en_n,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_step_n,
  input wire logic seq_order_sel,
  input wire logic [LANES-1:0] lane_write_n,
  input wire logic all_lanes_write_n,
  input wire logic lane_write_qual_n,
  input wire logic chip_sel_primary_n,
  input wire logic depth_sel_hi,
  input wire logic depth_sel_lo_n,
  input wire logic sleep_req
);

  localparam int BW = fbs_pkg::BURST_W;
  localparam int HI_W = ADDR_W - BW;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int LOG_W = ADDR_W + 1;

  fbs_pkg::fbs_ctl_s ctl;
  fbs_pkg::fbs_cyc_e cyc_reg;
  fbs_pkg::fbs_cyc_e cyc_next;
  logic [HI_W-1:0] addr_hi_reg;
  logic [LANES*LANE_W-1:0] din_reg;
  logic [LANES-1:0] mask_reg;
  logic [LANES-1:0] wr_mask;
  logic [BW-1:0] low_bits;
  logic [ADDR_W-1:0] cur_addr;
  logic awake;
  logic sel_ok;
  logic start;
  logic step;
  logic low_power_reg;
  logic [1:0] ctrl_reg;
  logic log_ovf_reg;
  logic log_in_valid;
  logic log_in_ready;
  logic log_out_valid;
  logic log_pop;
  logic [LOG_W-1:0] log_in_data;
  logic [LOG_W-1:0] log_out_data;
  logic ahb_take;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] status_word;
  logic [31:0] read_word;

  ////////////////////////////////////////////////////////////////////////////
  // Memory-side decode.

  // Group the sampled control pins.
  assign ctl = {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n, chip_sel_primary_n,
                depth_sel_hi, depth_sel_lo_n, all_lanes_write_n, lane_write_qual_n};

  // Sleep freezes every capture, which is how the internal clock is stopped.
  assign awake = !sleep_req; // R16
  assign sel_ok = !ctl.se1_n && ctl.se2 && !ctl.se3_n; // R14 R15

  // The processor strobe counts only while the primary enable is asserted.
  assign start = (!ctl.proc_n && !ctl.se1_n) || !ctl.ctrl_n; // R6 R9 R10
  assign step = awake && !start && !ctl.step_n && (cyc_reg != fbs_pkg::CYC_DESEL); // R7
  assign cur_addr = {addr_hi_reg, low_bits};

  // Global write overrides everything; otherwise the qualifier gates the lanes.
  always_comb begin
    if (!ctl.all_n) begin
      wr_mask = '1; // R4
    end else if (!ctl.qual_n) begin
      wr_mask = ~lane_write_n; // R3 R4
    end else begin
      wr_mask = '0;
    end
  end

  // A cycle with no lane to write is a read, including a bare qualifier.
  always_comb begin
    if (start && !sel_ok) begin
      cyc_next = fbs_pkg::CYC_DESEL; // R9 R14 R15
    end else if (start || (cyc_reg != fbs_pkg::CYC_DESEL)) begin
      cyc_next = (wr_mask != '0) ? fbs_pkg::CYC_WRITE : fbs_pkg::CYC_READ; // R18
    end else begin
      cyc_next = fbs_pkg::CYC_DESEL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input capture registers.

  // Cycle kind, write data and lane mask are taken at every running edge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_reg <= fbs_pkg::CYC_DESEL;
      din_reg <= '0;
      mask_reg <= '0;
    end else if (awake) begin
      cyc_reg <= cyc_next; // R1
      din_reg <= data_io_lane_i; // R1
      mask_reg <= wr_mask; // R1
    end
  end

  // A strobe aborts any burst and loads the new upper address.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_hi_reg <= '0;
    end else if (awake && start) begin
      addr_hi_reg <= addr_in; // R1 R9 R10
    end
  end

  // Low power holds after sleep until a read or write is commanded.
  // Only a fresh selected strobe counts; a burst frozen by sleep resuming is no command.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_power_reg <= 1'b0;
    end else if (sleep_req) begin
      low_power_reg <= 1'b1; // R16
    end else if (start && sel_ok) begin
      low_power_reg <= 1'b0; // R16
    end
  end

  // The burst bits pins must carry the bus's lowest address bits.
  fbs_burst_ctr #(
    .W(BW)
  ) u_burst (
    .clk(hclk),
    .rst_n(hresetn),
    .load(awake && start), // R6 R13
    .load_val(burst_low_bits),
    .step(step), // R7
    .interleave(seq_order_sel), // R8
    .low_bits(low_bits)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Array, one bank per lane.

  // A captured write lands at the next edge, so no external pulse is needed.
  // Lanes are separate banks so that each has a single writer.
  for (genvar l = 0; l < LANES; l++) begin : gen_lane
    logic [LANE_W-1:0] lane_mem [DEPTH];

    always_ff @(posedge hclk) begin
      if (cyc_reg == fbs_pkg::CYC_WRITE && mask_reg[l] && !ctrl_reg[fbs_pkg::CTRL_WR_BLOCK]) begin
        lane_mem[cur_addr] <= din_reg[l*LANE_W +: LANE_W]; // R2 R3 R5
      end
    end

    // Read data flows through from the addressed word with no output stage.
    assign data_io_lane_o[l*LANE_W +: LANE_W] = lane_mem[cur_addr]; // R12
  end

  // The output enable pin acts at once; it is not clocked, by design.
  assign data_io_lane_oe = !out_en_n && !sleep_req && !low_power_reg &&
                           (cyc_reg == fbs_pkg::CYC_READ); // R11

  ////////////////////////////////////////////////////////////////////////////
  // Access log buffer.

  // Each completed access is logged; a full buffer drops the entry and flags loss.
  assign log_in_valid = awake && ctrl_reg[fbs_pkg::CTRL_LOG_EN] &&
                        (cyc_reg != fbs_pkg::CYC_DESEL);
  assign log_in_data = {cyc_reg == fbs_pkg::CYC_WRITE, cur_addr};

  fbs_fifo #(
    .WIDTH(LOG_W),
    .DEPTH(fbs_pkg::LOG_DEPTH)
  ) u_log (
    .clk(hclk),
    .rst_n(hresetn),
    .in_valid(log_in_valid),
    .in_ready(log_in_ready),
    .in_data(log_in_data),
    .out_valid(log_out_valid),
    .out_ready(log_pop),
    .out_data(log_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  // Zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign ahb_take = hsel && hready && htrans[1];
  assign log_pop = ahb_take && !hwrite && (haddr[7:0] == fbs_pkg::OFF_LOG);

  // Status gathers live state of the memory side.
  always_comb begin
    status_word = '0;
    status_word[fbs_pkg::ST_LOW_POWER] = low_power_reg;
    status_word[fbs_pkg::ST_ACTIVE] = (cyc_reg != fbs_pkg::CYC_DESEL);
    status_word[fbs_pkg::ST_LOW_BITS +: BW] = low_bits;
    status_word[fbs_pkg::ST_LOG_OVF] = log_ovf_reg;
    status_word[fbs_pkg::ST_LOG_AVAIL] = log_out_valid;
    status_word[fbs_pkg::ST_MASK +: LANES] = mask_reg;
    status_word[fbs_pkg::ST_CYCLE +: 2] = cyc_reg;
  end

  // Unmapped offsets read as zero.
  always_comb begin
    read_word = '0;
    case (haddr[7:0])
      fbs_pkg::OFF_CTRL: begin
        read_word[1:0] = ctrl_reg;
      end
      fbs_pkg::OFF_STATUS: begin
        read_word = status_word;
      end
      fbs_pkg::OFF_LOG: begin
        read_word[LOG_W-1:0] = log_out_data;
        read_word[fbs_pkg::LOG_VALID_BIT] = log_out_valid;
      end
      default: begin
        read_word = '0;
      end
    endcase
  end

  // Read data is latched at the address phase so it stands for the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= '0;
    end else if (ahb_take && !hwrite) begin
      hrdata_reg <= read_word;
    end
  end

  // Write address phase is remembered until its data arrives.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else if (hready) begin
      wr_pend_reg <= ahb_take && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  // Control bits take effect at the end of the write data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= fbs_pkg::CTRL_RESET;
    end else if (wr_pend_reg && wr_addr_reg == fbs_pkg::OFF_CTRL) begin
      ctrl_reg <= hwdata[1:0];
    end
  end

  // A new loss in the clearing cycle wins over the clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      log_ovf_reg <= 1'b0;
    end else if (log_in_valid && !log_in_ready) begin
      log_ovf_reg <= 1'b1;
    end else if (wr_pend_reg && wr_addr_reg == fbs_pkg::OFF_STATUS &&
                 hwdata[fbs_pkg::ST_LOG_OVF]) begin
      log_ovf_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_r1_addr;
    awake && start |=> addr_hi_reg == $past(addr_in);
  endproperty
  a_r1_addr: assert property (p_r1_addr) else $error("strobe did not load address"); // R1

  property p_r3_lanes;
    awake && ctl.all_n && !ctl.qual_n |=> mask_reg == ~$past(lane_write_n);
  endproperty
  a_r3_lanes: assert property (p_r3_lanes) else $error("lane mask wrong"); // R3

  property p_r4_global;
    awake && start && sel_ok && !ctl.all_n |=> cyc_reg == fbs_pkg::CYC_WRITE && (&mask_reg);
  endproperty
  a_r4_global: assert property (p_r4_global) else $error("global write missed lanes"); // R4

  property p_r18_read;
    awake && start && sel_ok && ctl.all_n && !ctl.qual_n && (&lane_write_n)
      |=> cyc_reg == fbs_pkg::CYC_READ;
  endproperty
  a_r18_read: assert property (p_r18_read) else $error("empty write not a read"); // R18

  property p_r9_desel;
    awake && !ctl.ctrl_n && ctl.se1_n |=> cyc_reg == fbs_pkg::CYC_DESEL;
  endproperty
  a_r9_desel: assert property (p_r9_desel) else $error("controller strobe no deselect"); // R9

  property p_r10_block;
    awake && !ctl.proc_n && ctl.se1_n && ctl.ctrl_n |=> $stable(addr_hi_reg);
  endproperty
  a_r10_block: assert property (p_r10_block) else $error("blocked strobe loaded"); // R10

  property p_r15_depth;
    awake && start && !ctl.se2 |=> cyc_reg == fbs_pkg::CYC_DESEL;
  endproperty
  a_r15_depth: assert property (p_r15_depth) else $error("depth enable ignored"); // R15

  property p_r7_step;
    (step && !seq_order_sel) ##1 !seq_order_sel |-> low_bits == BW'($past(low_bits) + 1'b1);
  endproperty
  a_r7_step: assert property (p_r7_step) else $error("linear step wrong"); // R7

  property p_r16_sleep;
    sleep_req |=> low_power_reg && $stable(cyc_reg);
  endproperty
  a_r16_sleep: assert property (p_r16_sleep) else $error("sleep did not freeze"); // R16

  property p_r11_oe;
    out_en_n |-> !data_io_lane_oe;
  endproperty
  a_r11_oe: assert property (p_r11_oe) else $error("lanes driven while disabled"); // R11

  cover property (step [*3]);
  cover property (cyc_reg == fbs_pkg::CYC_WRITE ##1 cyc_reg == fbs_pkg::CYC_READ);
  cover property (sleep_req ##1 !sleep_req ##1 !low_power_reg);
  cover property (log_in_valid && !log_in_ready);

endmodule

`default_nettype wire

// ### fbs_cpu_model.sv
// Processor-side model that drives the memory pins of the burst port.
// Assumes the testbench resolves the shared data lanes and calls cyc once per clock.
`default_nettype none

module fbs_cpu_model (
  input wire logic hclk,
  output var fbs_pkg::fbs_ctl_s ctl,
  output logic [15:0] addr_hi,
  output logic [1:0] low_bits,
  output logic [3:0] lane_n,
  output logic [35:0] dq,
  output logic drive
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////////
  // Pins start idle: no strobe, no write, chip selected.
  initial begin
    ctl = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    addr_hi = 16'h0000;
    low_bits = 2'h0;
    lane_n = 4'hF;
    dq = 36'h000000000;
    drive = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One processor clock: pins change just after an edge and hold to the next.
  task automatic cyc(input fbs_pkg::fbs_ctl_s c, input logic [15:0] a, input logic [1:0] lo,
                     input logic [3:0] ln, input logic [35:0] d);
    logic wr;
    wr = !c.all_n || (!c.qual_n && ln != 4'hF);
    ctl <= c;
    addr_hi <= a;
    low_bits <= lo;
    lane_n <= ln;
    // Released lanes show the inverse of the last value, so a stale word cannot pass.
    dq <= wr ? d : ~dq;
    drive <= wr;
    @(posedge hclk);
  endtask
endmodule

`default_nettype wire

// ### tb_fbs_port.sv
// Self-checking testbench of the flow-through burst port with its processor model.
// Assumes a zero-wait bus slave and an array that starts unknown.
`default_nettype none

module tb_fbs_port;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {logic g; logic q; logic [3:0] ln; logic [35:0] d; logic [35:0] e;} fbs_row_s;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, low_bits;
  logic [15:0] addr_hi;
  logic [3:0] lane_n;
  logic [35:0] dq, dev_o, dq_bus;
  logic dev_oe, cpu_drive, out_en_n, order_sel, sleep_req;
  fbs_pkg::fbs_ctl_s ctl;
  int miscompares, cmp_count, k;
  fbs_row_s rows [7] = '{
    '{1'b0, 1'b1, 4'hF, 36'h000000000, 36'h000000000},
    '{1'b1, 1'b0, 4'hA, 36'hFFFFFFFFF, 36'h007FC01FF},
    '{1'b1, 1'b0, 4'hF, 36'h000000000, 36'h007FC01FF},
    '{1'b1, 1'b1, 4'h0, 36'h000000000, 36'h007FC01FF},
    '{1'b1, 1'b0, 4'h0, 36'hFFFFFFFFF, 36'hFFFFFFFFF},
    '{1'b1, 1'b0, 4'h5, 36'h000000000, 36'h007FC01FF},
    '{1'b0, 1'b0, 4'hF, 36'h000000000, 36'h000000000}};

  // The bus has one slave, and the lanes carry whichever party drives them.
  assign hready = hreadyout;
  assign dq_bus = (dev_oe && !cpu_drive) ? dev_o : dq;

  fbs_port u_fbs_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .addr_in(addr_hi),
    .burst_low_bits(low_bits), .data_io_lane_i(dq_bus), .data_io_lane_o(dev_o),
    .data_io_lane_oe(dev_oe), .out_en_n(out_en_n), .proc_addr_strobe_n(ctl.proc_n),
    .ctrl_addr_strobe_n(ctl.ctrl_n), .burst_step_n(ctl.step_n), .seq_order_sel(order_sel),
    .lane_write_n(lane_n), .all_lanes_write_n(ctl.all_n), .lane_write_qual_n(ctl.qual_n),
    .chip_sel_primary_n(ctl.se1_n), .depth_sel_hi(ctl.se2), .depth_sel_lo_n(ctl.se3_n),
    .sleep_req(sleep_req));

  fbs_cpu_model u_fbs_cpu_model (.hclk(hclk), .ctl(ctl), .addr_hi(addr_hi),
    .low_bits(low_bits), .lane_n(lane_n), .dq(dq), .drive(cpu_drive));

  ////////////////////////////////////////////////////////////////////////////////
  // Control word in pin order; the low depth enable stays asserted throughout.
  function automatic fbs_pkg::fbs_ctl_s cs(logic p, logic c, logic s, logic e1, logic e2,
                                           logic g, logic q);
    return '{p, c, s, e1, e2, 1'b0, g, q};
  endfunction

  // Distinct word for each burst location.
  function automatic logic [35:0] wv(int n);
    return 36'h3C0000000 + 36'(n);
  endfunction

  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One single transfer; the wait on ready is cut short only by the watchdog.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  // One memory clock at address 9, then the flow-through output is checked.
  task automatic go(input fbs_pkg::fbs_ctl_s c, input logic [1:0] lo, input logic eoe, int n);
    u_fbs_cpu_model.cyc(c, 16'h0009, lo, 4'hF, 36'h000000000);
    #1;
    chk("oe", {35'h0, eoe}, {35'h0, dev_oe});
    if (eoe) chk("data", wv(n), dev_o);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, and a watchdog sized well above the 84 cycles the tests take.
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  initial begin
    repeat (5000) @(posedge hclk);
    $display("watchdog expired");
    miscompares++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, out_en_n, order_sel, sleep_req} = '0;
    miscompares = 0;
    cmp_count = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 36'h0, {4'h0, rd});
    ahb(1'b1, 8'h0C, 32'hFFFFFFFF);
    ahb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 36'h0, {4'h0, rd});
    chk("hresp", 36'h0, {35'h0, hresp});
    $display("test registers done");
    // Each row accesses address 5 with its write controls and reads it straight back.
    foreach (rows[i]) begin
      u_fbs_cpu_model.cyc(cs(1, 0, 1, 0, 1, rows[i].g, rows[i].q), 16'h0005, 2'h0,
                          rows[i].ln, rows[i].d);
      u_fbs_cpu_model.cyc(cs(1, 0, 1, 0, 1, 1, 1), 16'h0005, 2'h0, 4'hF, 36'h0);
      #1;
      chk("row data", rows[i].e, dev_o);
    end
    $display("test lanes done");
    for (int n = 0; n < 4; n++) begin
      u_fbs_cpu_model.cyc(cs(1, 0, 1, 0, 1, 0, 1), 16'h0009, 2'(n), 4'hF, wv(n));
    end
    // The order strap moves only between bursts.
    for (int o = 0; o < 2; o++) begin
      order_sel <= o[0];
      go(cs(1, 0, 1, 0, 1, 1, 1), 2'h1, 1'b1, 1);
      for (int n = 1; n < 4; n++) begin
        k = o ? (1 ^ n) : ((1 + n) % 4);
        go(cs(1, 1, 0, 0, 1, 1, 1), 2'h0, 1'b1, k);
      end
      go(cs(1, 1, 1, 0, 1, 1, 1), 2'h0, 1'b1, k);
    end
    $display("test bursts done");
    go(cs(1, 0, 1, 0, 1, 1, 1), 2'h3, 1'b1, 3);
    go(cs(0, 1, 1, 1, 1, 1, 1), 2'h0, 1'b1, 3);
    go(cs(0, 1, 1, 0, 1, 1, 1), 2'h0, 1'b1, 0);
    go(cs(1, 0, 1, 0, 0, 1, 1), 2'h0, 1'b0, 0);
    go(cs(0, 1, 1, 0, 1, 1, 1), 2'h2, 1'b1, 2);
    go(cs(1, 0, 1, 1, 1, 1, 1), 2'h0, 1'b0, 0);
    go(cs(1, 0, 1, 0, 1, 1, 1), 2'h1, 1'b1, 1);
    // Output enable acts between clock edges.
    out_en_n <= 1'b1;
    #1;
    chk("oe async off", 36'h0, {35'h0, dev_oe});
    out_en_n <= 1'b0;
    #1;
    chk("oe async on", 36'h1, {35'h0, dev_oe});
    $display("test strobes done");
    // Sleep freezes the counter; the part stays quiet until a new access.
    sleep_req <= 1'b1;
    #1;
    chk("sleep oe", 36'h0, {35'h0, dev_oe});
    go(cs(1, 1, 0, 0, 1, 1, 1), 2'h0, 1'b0, 0);
    sleep_req <= 1'b0;
    go(cs(1, 1, 1, 0, 1, 1, 1), 2'h0, 1'b0, 0);
    ahb(1'b0, 8'h04, 32'h0);
    chk("low power", 36'h1, {35'h0, rd[0]});
    chk("frozen bits", 36'h1, {34'h0, rd[3:2]});
    go(cs(1, 0, 1, 0, 1, 1, 1), 2'h2, 1'b1, 2);
    $display("test sleep done");
    // A write attempted while the block bit is set must leave the word as it was.
    ahb(1'b1, 8'h00, 32'h1);
    u_fbs_cpu_model.cyc(cs(1, 0, 1, 0, 1, 0, 1), 16'h0009, 2'h0, 4'hF, 36'h0);
    go(cs(1, 0, 1, 0, 1, 1, 1), 2'h0, 1'b1, 0);
    ahb(1'b1, 8'h00, 32'h0);
    $display("test write block done");
    // Enough read edges to overrun the four-entry log, then drain it dry.
    go(cs(1, 0, 1, 0, 0, 1, 1), 2'h0, 1'b0, 0);
    ahb(1'b1, 8'h00, 32'h2);
    go(cs(1, 0, 1, 0, 1, 1, 1), 2'h0, 1'b1, 0);
    repeat (5) go(cs(1, 1, 1, 0, 1, 1, 1), 2'h0, 1'b1, 0);
    go(cs(1, 0, 1, 0, 0, 1, 1), 2'h0, 1'b0, 0);
    ahb(1'b1, 8'h00, 32'h0);
    ahb(1'b0, 8'h04, 32'h0);
    chk("log flags", 36'h3, {34'h0, rd[5:4]});
    chk("cycle kind", 36'h0, {34'h0, rd[13:12]});
    for (int i = 0; i < 5; i++) begin
      ahb(1'b0, 8'h08, 32'h0);
      chk("log entry", (i < 4) ? 36'h080000024 : 36'h0, (i < 4) ? {4'h0, rd} : {35'h0, rd[31]});
    end
    ahb(1'b1, 8'h04, 32'h10);
    ahb(1'b0, 8'h04, 32'h0);
    chk("overflow clear", 36'h0, {35'h0, rd[4]});
    $display("test log done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
